// ==== core/tcu_pkg.sv ====
// Package for the eight-bit timer/counter with one compare channel
package tcu_pkg;
  // Register map (word indices on the plain register port)
  localparam logic [2:0] ADDR_CONTROL = 3'h0;  // Clock select, waveform mode, output mode, force strobe
  localparam logic [2:0] ADDR_COUNTER = 3'h1;  // Counter value
  localparam logic [2:0] ADDR_COMPARE = 3'h2;  // Compare value (buffer or active)
  localparam logic [2:0] ADDR_FLAGS   = 3'h3;  // Flag register
  localparam logic [2:0] ADDR_MASK    = 3'h4;  // Mask register
  localparam logic [2:0] ADDR_ACTIVE  = 3'h5;  // Active compare value, read only

  // Control register field positions
  localparam int CS_LSB    = 0;  // Clock select field, three bits
  localparam int WGM_LSB   = 3;  // Waveform mode field, two bits
  localparam int COM_LSB   = 5;  // Output mode field, two bits
  localparam int FOC_BIT   = 7;  // Force-compare strobe, reads zero

  // Flag and mask bit positions
  localparam int OVF_BIT   = 0;  // Overflow
  localparam int CMP_BIT   = 1;  // Compare match

  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] COUNTER_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  localparam logic [1:0] MASK_RST    = 2'h0;

  // Counter limits
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL    = 8'hff;

  // Prescaler taps
  localparam int DIV_8    = 8;
  localparam int DIV_64   = 64;
  localparam int DIV_256  = 256;
  localparam int DIV_1024 = 1024;
  localparam int PRE_W    = 10;

  // Clock select codes
  typedef enum logic [2:0] {
    CS_STOP  = 3'b000,
    CS_DIV1  = 3'b001,
    CS_DIV8  = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } tcu_cs_type;

  // Waveform modes
  typedef enum logic [1:0] {
    WGM_NORMAL    = 2'b00,
    WGM_PHASE_PWM = 2'b01,
    WGM_CTC       = 2'b10,
    WGM_FAST_PWM  = 2'b11
  } tcu_wgm_type;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tcu_req_type;
endpackage : tcu_pkg

// ==== core/tcu_timer.sv ====
// Eight-bit timer/counter with compare channel, prescaler and register port
`timescale 1ns/10ps
// What this block does
// - Counter and compare are separate eight-bit registers
// - Clock select zero stops the counter; prescaler keeps running
// - Timer clock from prescaler or external pin edge
// - Counter zero raises the bottom indication
// - Counter 255 is the maximum
// - Top is 255 or compare, per mode
// - Each tick clears, increments or decrements counter
// - Software counter write beats clear and count
// - Waveform mode sets sequence and overflow condition
// - Continuous compare; flag set at next tick
// - Interrupt needs flag, enable and global enable
// - Flag cleared by service or writing one
// - Flags visible unmasked; each request gated by mask bit
// - Compare double buffered only in PWM modes
// - Buffer copied to active at top, count 255
// - Compare address reaches buffer or active register
// - Force strobe acts like match in non-PWM modes only, no flag, no clear
// - Counter write blocks matches next tick, even stopped
// - Mode change keeps compare output state
// - Output mode changes apply at once
// - Compare output state resets to zero
// - Output mode zero takes no action on match
// - Prescaler divides by 1, 8, 64, 256, 1024
module tcu_timer (
  input  wire logic              clk_sys,          // System clock
  input  wire logic              sys_rst,          // Asynchronous reset, active high
  input  tcu_pkg::tcu_req_type   reg_req,          // Register port request
  output logic [7:0]             reg_rdata,        // Read data, one cycle after read strobe
  input  wire logic              external_count_pin, // External count input, synchronous
  input  wire logic              global_irq_enable,  // Global enable from processor status
  input  wire logic              irq_ack_overflow,   // Overflow interrupt serviced, pulse
  input  wire logic              irq_ack_compare,    // Compare interrupt serviced, pulse
  output logic                   irq_overflow,     // Overflow request
  output logic                   irq_compare,      // Compare request
  output logic                   compare_output    // Internal compare output state
);

  // Control fields
  logic [2:0]  clock_select_field;          // Clock source choice
  logic [1:0]  waveform_mode_field;         // Counting sequence choice
  logic [1:0]  compare_output_mode_field;   // Output action choice
  logic [7:0]  counter_value_ff;            // Counter
  logic [7:0]  compare_value_ff;            // Active compare value
  logic [7:0]  compare_buf_ff;              // Buffered compare value
  logic [7:0]  control_ff;                  // Control register
  logic [1:0]  timer_flag_register_ff;      // Sticky flags
  logic [1:0]  timer_mask_register_ff;      // Interrupt masks
  logic        count_down_ff;               // Phase correct direction
  logic        block_ff;                    // Match blocked at next tick
  logic        match_pend_ff;               // Match seen, flag at next tick
  logic [tcu_pkg::PRE_W-1:0] pre_cnt_ff;    // Prescaler counter
  logic        ext_last_ff;                 // Previous pin level
  logic        compare_output_ff;           // Output state
  logic [7:0]  reg_rdata_ff;                // Read data register

  assign clock_select_field        = control_ff[tcu_pkg::CS_LSB +: 3];
  assign waveform_mode_field       = control_ff[tcu_pkg::WGM_LSB +: 2];
  assign compare_output_mode_field = control_ff[tcu_pkg::COM_LSB +: 2];

  // Decoded strobes
  logic wr_ctrl, wr_cnt, wr_cmp, wr_flag, wr_mask, force_stb;
  assign wr_ctrl   = reg_req.wr && (reg_req.addr == tcu_pkg::ADDR_CONTROL);
  assign wr_cnt    = reg_req.wr && (reg_req.addr == tcu_pkg::ADDR_COUNTER);
  assign wr_cmp    = reg_req.wr && (reg_req.addr == tcu_pkg::ADDR_COMPARE);
  assign wr_flag   = reg_req.wr && (reg_req.addr == tcu_pkg::ADDR_FLAGS);
  assign wr_mask   = reg_req.wr && (reg_req.addr == tcu_pkg::ADDR_MASK);
  assign force_stb = wr_ctrl && reg_req.wdata[tcu_pkg::FOC_BIT];

  // Mode helpers
  logic pwm_mode;
  assign pwm_mode = waveform_mode_field[0];

  // Prescaler free-runs; taps give one-cycle enables
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_ff <= '0;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 1'b1;
    end
  end

  // External pin edge detection; pin is taken as already synchronous
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ext_last_ff <= 1'b0;
    end else begin
      ext_last_ff <= external_count_pin;
    end
  end

  // Timer clock enable from clock select
  logic timer_clock;
  always_comb begin
    case (tcu_pkg::tcu_cs_type'(clock_select_field))
      tcu_pkg::CS_STOP:     timer_clock = 1'b0;
      tcu_pkg::CS_DIV1:     timer_clock = 1'b1;
      tcu_pkg::CS_DIV8:     timer_clock = (pre_cnt_ff[2:0] == '1);
      tcu_pkg::CS_DIV64:    timer_clock = (pre_cnt_ff[5:0] == '1);
      tcu_pkg::CS_DIV256:   timer_clock = (pre_cnt_ff[7:0] == '1);
      tcu_pkg::CS_DIV1024:  timer_clock = (pre_cnt_ff[9:0] == '1);
      tcu_pkg::CS_EXT_FALL: timer_clock = ext_last_ff && !external_count_pin;
      tcu_pkg::CS_EXT_RISE: timer_clock = !ext_last_ff && external_count_pin;
      default:              timer_clock = 1'b0;
    endcase
  end

  // Limits and top
  logic at_bottom, at_max, at_top, match;
  logic [7:0] top_val;
  assign at_bottom = (counter_value_ff == tcu_pkg::BOTTOM_VAL);
  assign at_max    = (counter_value_ff == tcu_pkg::MAX_VAL);
  // CTC uses the compare value as top; other modes use the maximum
  assign top_val   = (waveform_mode_field == tcu_pkg::WGM_CTC) ? compare_value_ff : tcu_pkg::MAX_VAL;
  assign at_top    = (counter_value_ff == top_val);
  assign match     = (counter_value_ff == compare_value_ff);

  // Next counter value and overflow event per mode
  logic [7:0] nxt_count;
  logic       nxt_down;
  logic       ovf_evt;
  always_comb begin
    nxt_count = counter_value_ff;
    nxt_down  = count_down_ff;
    ovf_evt   = 1'b0;
    case (tcu_pkg::tcu_wgm_type'(waveform_mode_field))
      tcu_pkg::WGM_NORMAL, tcu_pkg::WGM_FAST_PWM: begin
        nxt_count = counter_value_ff + 8'h01;
        nxt_down  = 1'b0;
        ovf_evt   = at_max;
      end
      tcu_pkg::WGM_CTC: begin
        // Clear on reaching top; overflow only on a pass through the maximum
        nxt_count = at_top ? tcu_pkg::BOTTOM_VAL : counter_value_ff + 8'h01;
        nxt_down  = 1'b0;
        ovf_evt   = at_max;
      end
      tcu_pkg::WGM_PHASE_PWM: begin
        // Dual slope: turn at top and bottom; overflow flagged at bottom
        if (count_down_ff) begin
          nxt_count = counter_value_ff - 8'h01;
          if (counter_value_ff == 8'h01) nxt_down = 1'b0;
        end else begin
          nxt_count = counter_value_ff + 8'h01;
          if (counter_value_ff == 8'hfe) nxt_down = 1'b1;
        end
        ovf_evt = at_bottom;
      end
      default: nxt_count = counter_value_ff;
    endcase
  end

  // Counter register; software write has priority
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      counter_value_ff <= tcu_pkg::COUNTER_RST;
      count_down_ff    <= 1'b0;
    end else if (wr_cnt) begin
      counter_value_ff <= reg_req.wdata;
    end else if (timer_clock) begin
      counter_value_ff <= nxt_count;
      count_down_ff    <= nxt_down;
    end
  end

  // Match blocking after counter write; lasts until the next tick
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      block_ff <= 1'b0;
    end else if (wr_cnt) begin
      block_ff <= 1'b1;
    end else if (timer_clock) begin
      block_ff <= 1'b0;
    end
  end

  // A match is seen on a tick and flagged on the following tick
  logic match_now;
  assign match_now = timer_clock && match && !block_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      match_pend_ff <= 1'b0;
    end else if (timer_clock) begin
      match_pend_ff <= match && !block_ff;
    end
  end

  // Control register; force bit is a strobe and is not stored
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      control_ff <= tcu_pkg::CONTROL_RST;
    end else if (wr_ctrl) begin
      control_ff <= {1'b0, reg_req.wdata[6:0]};
    end
  end

  // Compare buffer and active register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      compare_buf_ff <= tcu_pkg::COMPARE_RST;
    end else if (wr_cmp) begin
      compare_buf_ff <= reg_req.wdata;
    end
  end

  logic update_pt;
  assign update_pt = timer_clock &&
                     ((waveform_mode_field == tcu_pkg::WGM_FAST_PWM) ? at_max : at_top);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      compare_value_ff <= tcu_pkg::COMPARE_RST;
    end else if (!pwm_mode && wr_cmp) begin
      compare_value_ff <= reg_req.wdata;
    end else if (pwm_mode && update_pt) begin
      compare_value_ff <= compare_buf_ff;
    end
  end

  // Compare output waveform logic
  logic       force_act;
  logic [1:0] act_com;
  assign force_act = force_stb && !reg_req.wdata[tcu_pkg::WGM_LSB];
  // A force acts with the modes written beside it
  assign act_com   = force_act ? reg_req.wdata[tcu_pkg::COM_LSB +: 2] : compare_output_mode_field;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      compare_output_ff <= 1'b0;
    end else if (act_com != 2'b00) begin
      if (force_act || !pwm_mode) begin
        if (match_now || force_act) begin
          case (act_com)
            2'b01:   compare_output_ff <= !compare_output_ff;
            2'b10:   compare_output_ff <= 1'b0;
            2'b11:   compare_output_ff <= 1'b1;
            default: compare_output_ff <= compare_output_ff;
          endcase
        end
      end else if (waveform_mode_field == tcu_pkg::WGM_FAST_PWM) begin
        // Non-inverting clears on match and sets at bottom
        if (match_now) begin
          compare_output_ff <= (compare_output_mode_field == 2'b11);
        end else if (timer_clock && at_max) begin
          compare_output_ff <= (compare_output_mode_field != 2'b11);
        end
      end else if (match_now) begin
        // Phase correct non-inverting: up-count match clears, down-count match sets
        compare_output_ff <= (compare_output_mode_field == 2'b11) ^ count_down_ff;
      end
    end
  end
  // Mode writes touch only control_ff, so the output state is kept
  assign compare_output = compare_output_ff;

  // Flags: hardware set wins over clear by write-one or service
  logic [1:0] flag_set, flag_clr;
  assign flag_set[tcu_pkg::OVF_BIT] = timer_clock && ovf_evt;
  assign flag_set[tcu_pkg::CMP_BIT] = timer_clock && match_pend_ff;
  assign flag_clr[tcu_pkg::OVF_BIT] = irq_ack_overflow || (wr_flag && reg_req.wdata[tcu_pkg::OVF_BIT]);
  assign flag_clr[tcu_pkg::CMP_BIT] = irq_ack_compare || (wr_flag && reg_req.wdata[tcu_pkg::CMP_BIT]);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_flag
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          timer_flag_register_ff[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          timer_flag_register_ff[gi] <= 1'b1;
        end else if (flag_clr[gi]) begin
          timer_flag_register_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mask register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timer_mask_register_ff <= tcu_pkg::MASK_RST;
    end else if (wr_mask) begin
      timer_mask_register_ff <= reg_req.wdata[1:0];
    end
  end

  // Requests gated per bit and by the global enable
  assign irq_overflow = global_irq_enable && timer_flag_register_ff[tcu_pkg::OVF_BIT] &&
                        timer_mask_register_ff[tcu_pkg::OVF_BIT];
  assign irq_compare  = global_irq_enable && timer_flag_register_ff[tcu_pkg::CMP_BIT] &&
                        timer_mask_register_ff[tcu_pkg::CMP_BIT];

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        tcu_pkg::ADDR_CONTROL: reg_rdata_ff <= control_ff;
        tcu_pkg::ADDR_COUNTER: reg_rdata_ff <= counter_value_ff;
        tcu_pkg::ADDR_COMPARE: reg_rdata_ff <= pwm_mode ? compare_buf_ff : compare_value_ff;
        tcu_pkg::ADDR_FLAGS:   reg_rdata_ff <= {6'h00, timer_flag_register_ff};
        tcu_pkg::ADDR_MASK:    reg_rdata_ff <= {6'h00, timer_mask_register_ff};
        tcu_pkg::ADDR_ACTIVE:  reg_rdata_ff <= compare_value_ff;
        default:               reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_ff;

endmodule : tcu_timer

// ==== verification/tcu_timer_asserts.sv ====
// Assertion checker for the timer register port, requests and compare output
`timescale 1ns/10ps
module tcu_timer_asserts (
  input wire logic            clk_sys,
  input wire logic            sys_rst,
  input tcu_pkg::tcu_req_type reg_req,
  input wire logic [7:0]      reg_rdata,
  input wire logic            external_count_pin,
  input wire logic            global_irq_enable,
  input wire logic            irq_ack_overflow,
  input wire logic            irq_ack_compare,
  input wire logic            irq_overflow,
  input wire logic            irq_compare,
  input wire logic            compare_output
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic ctl_stop_wr;  // Control write that stops the clock; the old clock select can still tick in the write cycle
  logic irq_reg_wr;   // Write that may legally drop a request
  assign ctl_stop_wr = reg_req.wr && reg_req.addr == tcu_pkg::ADDR_CONTROL && reg_req.wdata[2:0] == 3'h0;
  assign irq_reg_wr  = reg_req.wr && (reg_req.addr == tcu_pkg::ADDR_FLAGS || reg_req.addr == tcu_pkg::ADDR_MASK);
  // Force strobe in a non-PWM mode with a given output mode
  sequence s_force(logic [1:0] com);
    ctl_stop_wr && reg_req.wdata[7] && !reg_req.wdata[3] && reg_req.wdata[6:5] == com;
  endsequence
  property p_force_set; s_force(2'h3) |=> compare_output; endproperty
  a_force_set: assert property (p_force_set) else $error("force set failed");
  property p_force_clr; s_force(2'h2) |=> !compare_output; endproperty
  a_force_clr: assert property (p_force_clr) else $error("force clear failed");
  property p_force_tgl; s_force(2'h1) |=> compare_output != $past(compare_output); endproperty
  a_force_tgl: assert property (p_force_tgl) else $error("force toggle failed");
  property p_com_off; s_force(2'h0) |=> $stable(compare_output); endproperty
  a_com_off: assert property (p_com_off) else $error("output moved, mode zero");
  property p_pwm_force; ctl_stop_wr && reg_req.wdata[7] && reg_req.wdata[3] |=> $stable(compare_output); endproperty
  a_pwm_force: assert property (p_pwm_force) else $error("force acted in a PWM mode");
  property p_irq_gate; irq_compare || irq_overflow |-> global_irq_enable; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without global enable");
  property p_ack; irq_ack_compare |=> !irq_compare; endproperty
  a_ack: assert property (p_ack) else $error("request survived service");
  property p_flag_wr; reg_req.wr && reg_req.addr == tcu_pkg::ADDR_FLAGS && reg_req.wdata[1] |=> !irq_compare; endproperty
  a_flag_wr: assert property (p_flag_wr) else $error("write-one kept flag");
  property p_hold;
    irq_compare && global_irq_enable && !irq_ack_compare && !irq_reg_wr |=> irq_compare || !global_irq_enable;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_rd_idle; !$past(reg_req.rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
endmodule : tcu_timer_asserts

bind tcu_timer tcu_timer_asserts i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .external_count_pin(external_count_pin), .global_irq_enable(global_irq_enable),
  .irq_ack_overflow(irq_ack_overflow), .irq_ack_compare(irq_ack_compare), .irq_overflow(irq_overflow),
  .irq_compare(irq_compare), .compare_output(compare_output));

// ==== verification/tcu_cpu_model.sv ====
// Processor-side model that services timer interrupt requests
`timescale 1ns/10ps
module tcu_cpu_model (
  input  wire logic       clk_sys,          // System clock
  input  wire logic       sys_rst,          // Asynchronous reset, active high
  input  wire logic       irq_compare,      // Compare request from the timer
  input  wire logic       irq_overflow,     // Overflow request from the timer
  input  wire logic       service_en,       // Handler entry allowed
  input  wire logic [3:0] service_delay,    // Cycles from request to handler entry
  output logic            irq_ack_compare,  // Compare handler entered, one cycle
  output logic            irq_ack_overflow  // Overflow handler entered, one cycle
);
  logic [3:0] wait_ff;  // Cycles the current request has waited
  logic       due;      // Handler may be entered this cycle
  assign due = service_en && wait_ff == service_delay && !irq_ack_compare && !irq_ack_overflow;
  // Latency count restarts after each service so one request is taken only once
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff <= 4'h0;
    end else if (!service_en || !(irq_compare || irq_overflow) || irq_ack_compare || irq_ack_overflow) begin
      wait_ff <= 4'h0;
    end else if (wait_ff != service_delay) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  // Only a raised request is serviced; compare has the higher priority
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ack_compare  <= 1'b0;
      irq_ack_overflow <= 1'b0;
    end else begin
      irq_ack_compare  <= due && irq_compare;
      irq_ack_overflow <= due && !irq_compare && irq_overflow;
    end
  end
endmodule : tcu_cpu_model

// ==== verification/testbench.sv ====
// Self-checking testbench for the eight-bit timer/counter
`timescale 1ns/10ps
module testbench;
  logic                 clk_sys, sys_rst, external_count_pin, global_irq_enable, service_en;
  logic                 irq_ack_overflow, irq_ack_compare, irq_overflow, irq_compare, compare_output;
  tcu_pkg::tcu_req_type reg_req;       // Register port request
  logic [7:0]           reg_rdata, d;  // Read data and last value read
  logic [3:0]           service_delay; // Handler latency of the model
  logic [4:0]           tbl [6];       // Force table: mode, output mode, expected output
  int                   errors, cmp_count, i, lo, hi;
  int                   divs [5];      // Prescaler factors per clock select code
  logic                 ok;

  tcu_timer i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .external_count_pin(external_count_pin), .global_irq_enable(global_irq_enable),
    .irq_ack_overflow(irq_ack_overflow), .irq_ack_compare(irq_ack_compare), .irq_overflow(irq_overflow),
    .irq_compare(irq_compare), .compare_output(compare_output));
  tcu_cpu_model i_cpu (.clk_sys(clk_sys), .sys_rst(sys_rst), .irq_compare(irq_compare),
    .irq_overflow(irq_overflow), .service_en(service_en), .service_delay(service_delay),
    .irq_ack_compare(irq_ack_compare), .irq_ack_overflow(irq_ack_overflow));

  // Free-running 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Prints the counts and the verdict, then stops
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // Compares with case equality so an unknown never passes
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One-cycle write after a free edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_req <= '{1'b1, 1'b0, a, v};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask : wr
  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    reg_req <= '0;
    #1 v = reg_rdata;
  endtask : rd
  // Bounded wait for a request; giving up ends the run
  task automatic wait_irq(input logic cmp, input int n);
    int k;
    k = 0;
    while ((cmp ? irq_compare : irq_overflow) !== 1'b1 && k < n) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= n) begin
      errors++;
      $display("CHECK FAILED request wait expected 1 seen 0");
      complete_run();
    end
  endtask : wait_irq
  // Three slow pulses on the count pin
  task automatic pulses3();
    repeat (3) begin
      @(posedge clk_sys);
      external_count_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      external_count_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask : pulses3
  function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] wgm, input logic [1:0] com, input logic f);
    return {f, com, wgm, cs};
  endfunction : ctl

  // Main sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    divs = '{1, tcu_pkg::DIV_8, tcu_pkg::DIV_64, tcu_pkg::DIV_256, tcu_pkg::DIV_1024};
    tbl = '{5'h03, 5'h12, 5'h07, 5'h01, 5'h14, 5'h07};
    sys_rst = 1'b1;
    reg_req = '0;
    {external_count_pin, global_irq_enable, service_en} = 3'h0;
    service_delay = 4'h3;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Reset values, unmapped place ignored
    chk("output after reset", compare_output, 1'b0);
    wr(3'h6, 8'hff);
    for (i = 0; i < 8; i++) begin
      rd(i[2:0], d);
      chk("reset register", d, 8'h00);
    end
    // Stopped counter holds; a counter write blocks the next match
    wr(tcu_pkg::ADDR_COUNTER, 8'h5a);
    repeat (20) @(posedge clk_sys);
    rd(tcu_pkg::ADDR_COUNTER, d);
    chk("stopped counter", d, 8'h5a);
    wr(tcu_pkg::ADDR_COMPARE, 8'h5a);
    rd(tcu_pkg::ADDR_ACTIVE, d);
    chk("direct compare", d, 8'h5a);
    wr(tcu_pkg::ADDR_COUNTER, 8'h5a);
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
    repeat (20) @(posedge clk_sys);
    wr(tcu_pkg::ADDR_CONTROL, 8'h00);
    rd(tcu_pkg::ADDR_FLAGS, d);
    chk("blocked match", d[1], 1'b0);
    // Compare flag, gating and clearing
    wr(tcu_pkg::ADDR_MASK, 8'h02);
    global_irq_enable <= 1'b1;
    wr(tcu_pkg::ADDR_COMPARE, 8'h20);
    wr(tcu_pkg::ADDR_COUNTER, 8'h10);
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
    wait_irq(1'b1, 100);
    wr(tcu_pkg::ADDR_CONTROL, 8'h00);
    rd(tcu_pkg::ADDR_FLAGS, d);
    chk("compare flag", d[1], 1'b1);
    global_irq_enable <= 1'b0;
    #1 chk("global off", irq_compare, 1'b0);
    global_irq_enable <= 1'b1;
    #1 chk("global on", irq_compare, 1'b1);
    wr(tcu_pkg::ADDR_MASK, 8'h00);
    #1 chk("masked", irq_compare, 1'b0);
    wr(tcu_pkg::ADDR_MASK, 8'h02);
    wr(tcu_pkg::ADDR_FLAGS, 8'h01);
    #1 chk("other bit written", irq_compare, 1'b1);
    wr(tcu_pkg::ADDR_FLAGS, 8'h02);
    #1 chk("write one clears", irq_compare, 1'b0);
    // Serviced requests, slow and prompt
    service_en <= 1'b1;
    wr(tcu_pkg::ADDR_COUNTER, 8'h10);
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
    wait_irq(1'b1, 100);
    repeat (8) @(posedge clk_sys);
    #1 chk("serviced compare", irq_compare, 1'b0);
    service_delay <= 4'h0;
    wr(tcu_pkg::ADDR_MASK, 8'h01);
    wr(tcu_pkg::ADDR_COUNTER, 8'hf0);
    wait_irq(1'b0, 40);
    repeat (3) @(posedge clk_sys);
    #1 chk("serviced overflow", irq_overflow, 1'b0);
    global_irq_enable <= 1'b0;
    service_en <= 1'b0;
    // External pin, rising then falling edges
    wr(tcu_pkg::ADDR_CONTROL, 8'h00);
    wr(tcu_pkg::ADDR_COUNTER, 8'h00);
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h7, 2'h0, 2'h0, 1'b0));
    pulses3();
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h6, 2'h0, 2'h0, 1'b0));
    pulses3();
    wr(tcu_pkg::ADDR_CONTROL, 8'h00);
    rd(tcu_pkg::ADDR_COUNTER, d);
    chk("pin edges", d, 8'h06);
    // Every prescaler code over a fixed run
    for (i = 1; i < 6; i++) begin
      wr(tcu_pkg::ADDR_COUNTER, 8'h00);
      wr(tcu_pkg::ADDR_CONTROL, ctl(i[2:0], 2'h0, 2'h0, 1'b0));
      repeat (200) @(posedge clk_sys);
      wr(tcu_pkg::ADDR_CONTROL, 8'h00);
      rd(tcu_pkg::ADDR_COUNTER, d);
      hi = 202 / divs[i-1] + 1;
      lo = (hi > 1) ? hi - 2 : 0;
      ok = (d >= lo && d <= hi);
      chk("prescaled count", ok, 1'b1);
    end
    // Compare-cleared sequence stays at or below top
    wr(tcu_pkg::ADDR_COMPARE, 8'h05);
    wr(tcu_pkg::ADDR_COUNTER, 8'h00);
    wr(tcu_pkg::ADDR_FLAGS, 8'h03);
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h1, 2'h2, 2'h0, 1'b0));
    ok = 1'b1;
    repeat (20) begin
      rd(tcu_pkg::ADDR_COUNTER, d);
      if (d > 8'h05) ok = 1'b0;
    end
    chk("top from compare", ok, 1'b1);
    rd(tcu_pkg::ADDR_FLAGS, d);
    chk("flags at top", d[1:0], 2'h2);
    // Force strobe across output modes, stopped
    wr(tcu_pkg::ADDR_CONTROL, 8'h00);
    wr(tcu_pkg::ADDR_FLAGS, 8'h03);
    wr(tcu_pkg::ADDR_COUNTER, 8'h77);
    for (i = 0; i < 6; i++) begin
      wr(tcu_pkg::ADDR_CONTROL, ctl(3'h0, tbl[i][4:3], tbl[i][2:1], 1'b1));
      #1 chk("forced output", compare_output, tbl[i][0]);
    end
    rd(tcu_pkg::ADDR_FLAGS, d);
    chk("force sets no flag", d, 8'h00);
    rd(tcu_pkg::ADDR_COUNTER, d);
    chk("force keeps count", d, 8'h77);
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h0, 2'h3, 2'h0, 1'b0));
    #1 chk("mode change keeps", compare_output, 1'b1);
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h0, 2'h3, 2'h2, 1'b1));
    #1 chk("force in PWM", compare_output, 1'b1);
    rd(tcu_pkg::ADDR_CONTROL, d);
    chk("strobe reads zero", d, 8'h58);
    // Buffered compare in fast PWM, loaded only at the sequence limit
    wr(tcu_pkg::ADDR_COMPARE, 8'h40);
    rd(tcu_pkg::ADDR_COMPARE, d);
    chk("buffer read", d, 8'h40);
    rd(tcu_pkg::ADDR_ACTIVE, d);
    chk("active held", d, 8'h05);
    wr(tcu_pkg::ADDR_CONTROL, ctl(3'h1, 2'h3, 2'h0, 1'b0));
    i = 0;
    do begin
      rd(tcu_pkg::ADDR_ACTIVE, d);
      i++;
    end while (d !== 8'h40 && i < 200);
    chk("buffer loaded", d, 8'h40);
    wr(tcu_pkg::ADDR_CONTROL, 8'h00);
    complete_run();
  end
endmodule : testbench
